// ===== design/asp_pkg.sv
// Package for the host-side controller of a 16-bit asynchronous static memory
package asp_pkg;

    localparam int ADDR_W = 17;        // Word address width
    localparam int DATA_W = 16;        // Data width, two byte lanes

    // Timing figures in ns and derived cycle counts at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_RC_NS       = 55;  // Least read cycle
    localparam int T_WC_NS       = 45;  // Least write cycle
    localparam int T_PWE_NS      = 35;  // Least write strobe pulse
    localparam int T_SD_NS       = 25;  // Least data setup to write end
    localparam int T_AA_NS       = 55;  // Longest address to data valid
    // Least times round up
    localparam int RD_CYC  = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RC_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWE_CYC = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SD_CYC  = (T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WC_CYC  = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W   = 4;         // Wide enough for every count above

    // Reset values
    localparam logic RST_CTRL_N = 1'b1; // All strobes idle high

    // Host request from the user side
    typedef struct packed {
        logic              write;       // 1 write, 0 read
        logic [ADDR_W-1:0] addr;        // Word address
        logic [DATA_W-1:0] wdata;       // Write data
        logic [1:0]        lane;        // Lane select, bit1 upper, bit0 lower
    } asp_req_s;

    // Memory control pins, all active low
    typedef struct packed {
        logic chip_select_n;
        logic write_strobe_n;
        logic output_enable_n;
        logic upper_lane_enable_n;
        logic lower_lane_enable_n;
    } asp_ctrl_s;

endpackage

// ===== design/asp_sync.sv
// Two-flop synchroniser for the data pins read back from the memory
module asp_sync #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r, s1_nxt;  // First stage, read only by the second
    logic [W-1:0] s2_r, s2_nxt;  // Second stage, safe to use

    // Shift the pin level along the chain
    always_comb begin
        s1_nxt = d;
        s2_nxt = s1_r;
    end

    // Register both stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    assign q = s2_r;
endmodule

// ===== design/asp_host.sv
// Host controller driving an asynchronous 16-bit static memory over its pins
module asp_host (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    // User request side
    input  wire logic                           req_valid,
    output logic                                req_ready,
    input  wire asp_pkg::asp_req_s              req,
    output logic                                rsp_valid,
    output logic      [asp_pkg::DATA_W-1:0]     rsp_rdata,
    // Memory pins
    output logic      [asp_pkg::ADDR_W-1:0]     mem_addr,
    output asp_pkg::asp_ctrl_s                  mem_ctrl,
    input  wire logic [asp_pkg::DATA_W-1:0]     mem_dq_i,
    output logic      [asp_pkg::DATA_W-1:0]     mem_dq_o,
    output logic      [asp_pkg::DATA_W-1:0]     mem_dq_oe_n
);
    // Sequencer states. A read sits in one state and counts; a write walks
    // through settle, strobe, end and recovery, so that each write strobe edge lands
    // on a clock edge of its own and never moves with chip select or the lanes.
    typedef enum logic [2:0] {
        ASP_IDLE,   // Waiting for a request
        ASP_RD,     // Read access, strobes active
        ASP_WSET,   // Address settle, write strobe still high
        ASP_WR,     // Write strobe low, data driven
        ASP_WEND,   // Write ended, data held one cycle
        ASP_REC     // Recovery to fill the cycle time
    } asp_state_e;

    // Registered state; every memory pin but the drive enables comes straight from one of these.
    // The request is latched whole when taken, so the pins never follow the
    // user side while an access is under way.
    asp_state_e                   st_r, st_nxt;         // Sequencer state
    logic [asp_pkg::CNT_W-1:0]    cnt_r, cnt_nxt;       // Phase counter
    logic [asp_pkg::ADDR_W-1:0]   addr_r, addr_nxt;     // Latched address
    logic [asp_pkg::DATA_W-1:0]   wd_r, wd_nxt;         // Latched write data
    logic [1:0]                   lane_r, lane_nxt;     // Latched lane select
    asp_pkg::asp_ctrl_s           ctrl_r, ctrl_nxt;     // Registered strobes
    logic                         drv_r, drv_nxt;       // Data pins driven
    logic [asp_pkg::DATA_W-1:0]   rd_r, rd_nxt;         // Captured read data
    logic                         rv_r, rv_nxt;         // Read data valid pulse
    logic [asp_pkg::DATA_W-1:0]   dq_sync;              // Synchronised pins

    // Pins are asynchronous to our clock, so pass two flops first
    // Limitation: pin data arrive two cycles late, which the read count
    // allows for, so the memory outputs are never sampled raw.
    asp_sync #(.W(asp_pkg::DATA_W)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (mem_dq_i),
        .q     (dq_sync)
    );

    // Ready only when idle; no queueing
    // A request offered while busy simply waits with valid held high
    assign req_ready = (st_r == ASP_IDLE);

    // Sequencer next state
    // Cycle walk, counted from the clock edge that takes the request (c0):
    //   read   c0       chip select, output enable and lanes go low
    //          c1..c7   counter runs while the memory settles its data
    //          c8       synchronised pins captured, strobes high,
    //                   response pulse raised, back to idle
    //   write  c0       chip select and lanes low, output enable stays high
    //          c1       write strobe low, data driven on selected lanes
    //          c5       write strobe high: the one edge that ends the write
    //          c6       chip select and lanes high, data still driven
    //          c7       data released, back to idle
    // Margins at 10 ns a clock:
    //   read strobes low 80 ns, pins sampled 60 ns after they fall
    //   write strobe low 40 ns, data driven 40 ns before it rises
    //   a whole write takes 70 ns
    // Trade-off: a fixed walk costs a cycle or two over the bare minimum,
    // but keeps every timing figure a whole number of clocks and lets the
    // strobe alone end each write, so setup and hold have one reference.
    always_comb begin
        // Hold everything unless a state says otherwise; the pulse drops
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        addr_nxt = addr_r;
        wd_nxt   = wd_r;
        lane_nxt = lane_r;
        ctrl_nxt = ctrl_r;
        drv_nxt  = drv_r;
        rd_nxt   = rd_r;
        rv_nxt   = 1'b0;
        unique case (st_r)
            // Idle keeps the memory deselected between accesses
            ASP_IDLE: begin
                // Default idle: deselected so the memory floats its pins
                ctrl_nxt = '{default: asp_pkg::RST_CTRL_N};
                drv_nxt  = 1'b0;
                // An empty lane mask selects nothing, so it is dropped here
                if (req_valid && (req.lane != 2'b00)) begin
                    addr_nxt = req.addr;
                    wd_nxt   = req.wdata;
                    lane_nxt = req.lane;
                    cnt_nxt  = '0;
                    ctrl_nxt.chip_select_n       = 1'b0;
                    // Lane enables follow the mask: bit one upper, bit zero lower
                    ctrl_nxt.upper_lane_enable_n = ~req.lane[1];
                    ctrl_nxt.lower_lane_enable_n = ~req.lane[0];
                    if (req.write) begin
                        // Output enable held high so the memory never drives
                        ctrl_nxt.output_enable_n = 1'b1;
                        st_nxt = ASP_WSET;
                    end else begin
                        ctrl_nxt.output_enable_n = 1'b0;
                        ctrl_nxt.write_strobe_n  = 1'b1;
                        st_nxt = ASP_RD;
                    end
                end
            end

            ASP_RD: begin
                // Wait the read cycle time plus the two synchroniser stages;
                // only a reset can cut a read short
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == asp_pkg::CNT_W'(asp_pkg::RC_CYC + 1)) begin
                    rd_nxt = dq_sync;
                    // Unselected lane reads as zero since its pins float
                    if (!lane_r[1]) rd_nxt[15:8] = 8'h00;
                    if (!lane_r[0]) rd_nxt[7:0]  = 8'h00;
                    rv_nxt   = 1'b1;
                    ctrl_nxt = '{default: asp_pkg::RST_CTRL_N};
                    st_nxt   = ASP_IDLE;
                end
            end

            ASP_WSET: begin
                // Address and lanes settled one cycle before the strobe
                ctrl_nxt.write_strobe_n = 1'b0;
                drv_nxt = 1'b1;
                cnt_nxt = '0;
                st_nxt  = ASP_WR;
            end

            ASP_WR: begin
                // Strobe low long enough for both pulse and data setup
                // Data have stood since the strobe fell, past the setup time
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == asp_pkg::CNT_W'(asp_pkg::PWE_CYC - 1)) begin
                    ctrl_nxt.write_strobe_n = 1'b1;
                    st_nxt  = ASP_WEND;
                end
            end

            ASP_WEND: begin
                // Write strobe ended the write; hold data and address a cycle
                // Chip select and lanes rise now, a cycle after the strobe
                ctrl_nxt = '{default: asp_pkg::RST_CTRL_N};
                cnt_nxt  = '0;
                st_nxt   = ASP_REC;
            end

            ASP_REC: begin
                // Release data one cycle after the strobes, before any read
                // The memory is deselected now, so there is no fight on release
                drv_nxt = 1'b0;
                st_nxt  = ASP_IDLE;
            end

            // Unused codes fall back to idle; strobes hold until idle sets them high
            default: st_nxt = ASP_IDLE;
        endcase
    end

    // Sequencer registers
    // Reset loads constants only; strobes idle high so the memory stays deselected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= ASP_IDLE;
            cnt_r  <= '0;
            addr_r <= '0;
            wd_r   <= '0;
            lane_r <= '0;
            ctrl_r <= '{default: asp_pkg::RST_CTRL_N};
            drv_r  <= 1'b0;
            rd_r   <= '0;
            rv_r   <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            addr_r <= addr_nxt;
            wd_r   <= wd_nxt;
            lane_r <= lane_nxt;
            ctrl_r <= ctrl_nxt;
            drv_r  <= drv_nxt;
            rd_r   <= rd_nxt;
            rv_r   <= rv_nxt;
        end
    end

    // Pin outputs. Address, data and strobes all leave flops on one edge,
    // so the skew between them is only pad and board delay.
    assign mem_addr    = addr_r;
    assign mem_ctrl    = ctrl_r;
    assign mem_dq_o    = wd_r;
    assign rsp_valid   = rv_r;
    assign rsp_rdata   = rd_r;

    // Drive enables per lane, low while we drive; an unselected lane is
    // never driven, so its half of the bus stays free for the memory
    for (genvar g = 0; g < 2; g++) begin : g_lane
        assign mem_dq_oe_n[g*8 +: 8] = {8{~(drv_r & lane_r[g])}};
    end
endmodule

// ===== tb/asp_monitor.sv
// Pin-timing checker for the host controller, bound to its top module
module asp_monitor (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic [16:0]        mem_addr,
    input wire asp_pkg::asp_ctrl_s mem_ctrl,
    input wire logic [15:0]        mem_dq_o,
    input wire logic [15:0]        mem_dq_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking mcb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Active-high views of the low-true strobes
    wire cs = !mem_ctrl.chip_select_n;
    wire we = !mem_ctrl.write_strobe_n;
    wire oe = !mem_ctrl.output_enable_n;
    wire ln = !(mem_ctrl.upper_lane_enable_n && mem_ctrl.lower_lane_enable_n);
    rd_we_idle_a: assert property (cs && oe |-> !we)
        else $error("write strobe low in read");
    no_contend_a: assert property (!(&mem_dq_oe_n) |-> !oe)
        else $error("host drives while memory drives");
    we_pulse_a: assert property ($rose(we) |-> we [*4])
        else $error("write pulse short");
    wr_frame_a: assert property (we |-> cs && ln && $past(cs))
        else $error("write outside select overlap");
    addr_hold_a: assert property (we || $fell(we) |-> $stable(mem_addr))
        else $error("address moved in write");
    data_hold_a: assert property ($fell(we) |=> $stable(mem_dq_o) && !(&mem_dq_oe_n))
        else $error("data released at write end");
    data_setup_a: assert property ($fell(we) |-> mem_dq_o == $past(mem_dq_o, 3)
        && !(&$past(mem_dq_oe_n, 3)))
        else $error("data setup short");
    wr_end_order_a: assert property ($fell(we) |-> cs && ln)
        else $error("select rose together with write strobe");
    rd_cycle_a: assert property ($rose(oe) |-> oe [*6])
        else $error("read cycle short");
    // Main scenarios: read, write with the upper lane, lower-lane-only write
    cover property ($rose(oe));
    cover property ($rose(we) && !mem_ctrl.upper_lane_enable_n);
    cover property (we && mem_ctrl.upper_lane_enable_n);
endmodule
bind asp_host asp_monitor asp_monitor_inst (.clk, .rst_n, .mem_addr, .mem_ctrl, .mem_dq_o,
    .mem_dq_oe_n);

// ===== tb/asp_sram_model.sv
// Behavioural static memory standing on the far side of the pins
module asp_sram_model (
    input  wire logic               clk,
    input  wire logic [16:0]        a,
    input  wire asp_pkg::asp_ctrl_s c,
    input  wire logic [15:0]        hd,
    input  wire logic [15:0]        hoe_n,
    output logic      [15:0]        dq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [256];     // Low address bits only, enough for the bench
    logic [15:0] flt = 16'h5a5a; // Undriven pins wander so stale data never passes
    logic [15:0] drv;           // Bits the memory drives
    wire sel = !c.chip_select_n && !(c.upper_lane_enable_n && c.lower_lane_enable_n);
    wire wr = sel && !c.write_strobe_n;
    wire rd = sel && c.write_strobe_n && !c.output_enable_n;
    // Floating pattern flips each cycle
    always @(posedge clk) flt <= ~flt;
    // Store lane by lane when the overlap ends
    always @(negedge wr) begin
        if (!c.lower_lane_enable_n) mem[a[7:0]][7:0] = dq[7:0];
        if (!c.upper_lane_enable_n) mem[a[7:0]][15:8] = dq[15:8];
    end
    // Resolve pins; a fight between both parties shows as unknown
    always_comb begin
        drv = {{8{rd && !c.upper_lane_enable_n}}, {8{rd && !c.lower_lane_enable_n}}};
        for (int i = 0; i < 16; i++)
            dq[i] = (!hoe_n[i] && drv[i]) ? 1'bx :
                    !hoe_n[i] ? hd[i] : drv[i] ? mem[a[7:0]][i] : flt[i];
    end
endmodule

// ===== tb/async_sram_16bit_byte_lane_port_bench.sv
// Self-checking bench: host controller against the memory model
module async_sram_16bit_byte_lane_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        asp_pkg::asp_req_s r;   // Request
        logic [15:0]       exp; // Expected read data
    } asp_row_s;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               req_valid = 1'b0;
    asp_pkg::asp_req_s  req = '0;
    logic               req_ready, rsp_valid;
    logic [15:0]        rsp_rdata, dq, dq_o, dq_oe_n;
    logic [16:0]        addr;
    asp_pkg::asp_ctrl_s ctrl;
    asp_row_s           rows [7];
    int                 errors = 0;
    int                 tests_run = 0;
    int                 cyc = 0;
    asp_host asp_host_inst (.clk, .rst_n, .req_valid, .req_ready, .req, .rsp_valid, .rsp_rdata,
        .mem_addr(addr), .mem_ctrl(ctrl), .mem_dq_i(dq), .mem_dq_o(dq_o), .mem_dq_oe_n(dq_oe_n));
    asp_sram_model asp_sram_model_inst (.clk, .a(addr), .c(ctrl), .hd(dq_o), .hoe_n(dq_oe_n),
        .dq);
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One request: held until taken, then wait for completion under a bound
    task automatic run(input asp_row_s w);
        int n;
        n = 0;
        req <= w.r;
        req_valid <= 1'b1;
        do begin @(posedge clk); n++; end while (!req_ready && n < 20);
        req_valid <= 1'b0;
        do begin @(posedge clk); n++; end while (n < 40 && !(w.r.write ? req_ready : rsp_valid));
        chk({15'h0, n < 40}, 16'h1);
        if (!w.r.write) chk(rsp_rdata, w.exp);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        rows[0] = '{'{1'b1, 17'h5, 16'h1234, 2'h3}, 16'h0};
        rows[1] = '{'{1'b0, 17'h5, 16'h0, 2'h3}, 16'h1234};
        rows[2] = '{'{1'b1, 17'h5, 16'habcd, 2'h1}, 16'h0};
        rows[3] = '{'{1'b0, 17'h5, 16'h0, 2'h3}, 16'h12cd};
        rows[4] = '{'{1'b1, 17'h5, 16'h9900, 2'h2}, 16'h0};
        rows[5] = '{'{1'b0, 17'h5, 16'h0, 2'h1}, 16'h00cd};
        rows[6] = '{'{1'b0, 17'h5, 16'h0, 2'h2}, 16'h9900};
        repeat (3) @(posedge clk);
        chk({11'h0, ctrl}, 16'h001f);
        chk(dq_oe_n, 16'hffff);
        chk({14'h0, req_ready, rsp_valid}, 16'h0002);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++)
            run(rows[i]);
        // Empty lane mask must be dropped and leave memory alone
        req <= '{1'b1, 17'h5, 16'hdead, 2'h0};
        req_valid <= 1'b1;
        repeat (2) @(posedge clk);
        req_valid <= 1'b0;
        chk({11'h0, ctrl}, 16'h001f);
        chk({15'h0, req_ready}, 16'h0001);
        @(posedge clk);
        run('{'{1'b0, 17'h5, 16'h0, 2'h3}, 16'h99cd});
        // Reset in mid-read must release every strobe at once
        req <= rows[1].r;
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        @(posedge clk);
        chk({11'h0, ctrl}, 16'h0008);
        chk(addr[15:0], 16'h0005);
        rst_n <= 1'b0;
        @(posedge clk);
        chk({11'h0, ctrl}, 16'h001f);
        chk(dq_oe_n, 16'hffff);
        chk({14'h0, req_ready, rsp_valid}, 16'h0002);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        run('{'{1'b0, 17'h5, 16'h0, 2'h3}, 16'h99cd});
        close_out();
    end
endmodule
